// [src/eip_external_irq.sv]
// Overview of operation
// - Five external sources exist: three maskable user inputs, one nonmaskable input, one drive protect input.
// - The first user input is a type A source controlled and reported at index 7070h.
// - The first user input works as a level 1 request, a level 6 request, or an input-only pin.
// - The nonmaskable input is controlled at 7072h and acts as a nonmaskable request or an input pin.
// - The second user input is a type C source at 7078h: level 1, level 6, or a two-way pin.
// - The third user input is a type C source at 707Ah: level 1, level 6, or a two-way pin.
// - An enabled drive protect event floats the timer and PWM outputs and signals the CPU.
// - The drive protect request is maskable and always goes to core line two.
// - At low priority the user sources rank one, two, three and give vectors 0001h, 0011h, 001Fh.
// - The third user register at 707Ah is separate from every other source register.
// - Each source has a flag set on request and an enable; only both set are forwarded.
// - An acknowledge with nothing requesting on that line yields the phantom vector 0000h.
// - At high priority the user sources go to core line one with the same vectors and order.
//
// The implementer's own choice: register access over APB.
module eip_external_irq (
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [eip_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        extIrqOnePin,
  input  wire logic                        nmiPin,
  input  wire logic                        extIrqTwoIn,
  output logic                             extIrqTwoOut,
  output logic                             extIrqTwoOe,
  input  wire logic                        extIrqThreeIn,
  output logic                             extIrqThreeOut,
  output logic                             extIrqThreeOe,
  input  wire logic                        driveFaultN,
  output logic                             timerPwmHiZ,
  input  wire logic                        ackLineOne,
  input  wire logic                        ackLineSix,
  output eip_pkg::eip_core_req_t           coreReq,
  output logic                             irq
);

  logic                          rstMeta;
  logic                          rstSync;
  logic                          armed;
  eip_pkg::eip_ctrl_t            ctrl     [eip_pkg::NUM_SRC];
  logic [15:0]                   ctrlView [eip_pkg::NUM_SRC];
  logic [eip_pkg::NUM_SRC-1:0]   flag;
  logic [eip_pkg::NUM_SRC-1:0]   pinNow;
  logic [eip_pkg::NUM_SRC-1:0]   pinPrev;
  logic [eip_pkg::NUM_SRC-1:0]   srcEvt;
  logic [eip_pkg::NUM_SRC-1:0]   enBits;
  logic [eip_pkg::NUM_SRC-1:0]   fwd;
  logic [eip_pkg::NUM_SRC-1:0]   wrSel;
  logic [eip_pkg::NUM_SRC-1:0]   status;
  logic [eip_pkg::NUM_SRC-1:0]   mask;
  logic [eip_pkg::NUM_SRC-1:0]   rdClr;
  logic [2:0]                    userFwd;
  logic [2:0]                    userPrio;
  logic [2:0]                    highPend;
  logic [2:0]                    lowPend;
  logic [15:0]                   vector;
  logic [31:0]                   rdMux;
  logic                          rdHit;
  logic                          rsvHit;
  logic                          setupPh;
  logic                          accessPh;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  assign setupPh  = psel & ~penable;
  assign accessPh = psel & penable & pready;

  // Pin levels by slot; the protect input is active low
  assign pinNow = {~driveFaultN, extIrqThreeIn, extIrqTwoIn, nmiPin, extIrqOnePin};

  // Previous levels; armed blocks a false edge on the first cycle
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      pinPrev <= '0;
      armed   <= 1'b0;
    end else begin
      pinPrev <= pinNow;
      armed   <= 1'b1;
    end
  end

  // Edge events per source; GPIO mode raises no request
  always_comb begin
    for (int i = 0; i < eip_pkg::NUM_SRC; i++) begin
      srcEvt[i] = armed & ~ctrl[i].gpio &
                  (ctrl[i].pol ? (pinNow[i] & ~pinPrev[i]) : (~pinNow[i] & pinPrev[i]));
      enBits[i] = ctrl[i].en;
    end
    srcEvt[eip_pkg::SRC_PROT] = armed & pinNow[eip_pkg::SRC_PROT] & ~pinPrev[eip_pkg::SRC_PROT];
  end

  // Write select per source register, each at its own address
  always_comb begin
    for (int i = 0; i < eip_pkg::NUM_SRC; i++) begin
      wrSel[i] = accessPh & pwrite & (paddr == eip_pkg::SRC_ADDR[i]);
    end
  end

  // Software control bits; unwritable bits are held at zero
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      for (int i = 0; i < eip_pkg::NUM_SRC; i++) begin
        ctrl[i] <= eip_pkg::eip_ctrl_t'(eip_pkg::CTRL_RESET);
      end
    end else begin
      for (int i = 0; i < eip_pkg::NUM_SRC; i++) begin
        if (wrSel[i]) begin
          ctrl[i] <= eip_pkg::eip_ctrl_t'(pwdata[15:0] & eip_pkg::SRC_WMASK[i]);
        end
      end
    end
  end

  // Flags: hardware set beats a write-one clear in the same cycle
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      flag <= '0;
    end else begin
      flag <= (flag & ~(wrSel & {eip_pkg::NUM_SRC{pwdata[15]}})) | srcEvt;
    end
  end

  // Forwarding needs flag and enable together
  assign fwd      = flag & enBits;
  assign userFwd  = {fwd[eip_pkg::SRC_THREE], fwd[eip_pkg::SRC_TWO], fwd[eip_pkg::SRC_ONE]};
  assign userPrio = {ctrl[eip_pkg::SRC_THREE].prio, ctrl[eip_pkg::SRC_TWO].prio,
                     ctrl[eip_pkg::SRC_ONE].prio};
  assign highPend = userFwd & ~userPrio;
  assign lowPend  = userFwd & userPrio;

  // Core requests registered; protect always on line two
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      coreReq <= '0;
    end else begin
      coreReq.lineOne <= |highPend;
      coreReq.lineSix <= |lowPend;
      coreReq.lineTwo <= fwd[eip_pkg::SRC_PROT];
      coreReq.nmi     <= fwd[eip_pkg::SRC_NMI];
    end
  end

  // Fixed ranking: first, second, then third user source
  function automatic logic [15:0] pickVec(input logic [2:0] pend);
    logic [15:0] v;
    v = eip_pkg::VEC_PHANTOM;
    if (pend[2]) begin
      v = eip_pkg::VEC_THREE;
    end
    if (pend[1]) begin
      v = eip_pkg::VEC_TWO;
    end
    if (pend[0]) begin
      v = eip_pkg::VEC_ONE;
    end
    return v;
  endfunction

  // Vector captured at acknowledge; empty line gives the phantom code
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      vector <= eip_pkg::VEC_PHANTOM;
    end else if (ackLineOne) begin
      vector <= pickVec(highPend);
    end else if (ackLineSix) begin
      vector <= pickVec(lowPend);
    end
  end

  // Protect event floats drive outputs while flagged and enabled
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      timerPwmHiZ <= 1'b0;
    end else begin
      timerPwmHiZ <= fwd[eip_pkg::SRC_PROT];
    end
  end

  // Type C pins drive only in GPIO output mode
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      extIrqTwoOut   <= 1'b0;
      extIrqTwoOe    <= 1'b0;
      extIrqThreeOut <= 1'b0;
      extIrqThreeOe  <= 1'b0;
    end else begin
      extIrqTwoOut   <= ctrl[eip_pkg::SRC_TWO].dout;
      extIrqTwoOe    <= ctrl[eip_pkg::SRC_TWO].gpio & ctrl[eip_pkg::SRC_TWO].dir;
      extIrqThreeOut <= ctrl[eip_pkg::SRC_THREE].dout;
      extIrqThreeOe  <= ctrl[eip_pkg::SRC_THREE].gpio & ctrl[eip_pkg::SRC_THREE].dir;
    end
  end

  // Clear only the bits the read actually returned, so no event is lost
  assign rdClr = (accessPh & ~pwrite & (paddr == eip_pkg::ADDR_STATUS)) ?
                 prdata[eip_pkg::NUM_SRC-1:0] : '0;

  // Sticky event status, mask and the level interrupt
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      status <= '0;
      mask   <= '0;
      irq    <= 1'b0;
    end else begin
      status <= (status & ~rdClr) | srcEvt;
      if (accessPh & pwrite & (paddr == eip_pkg::ADDR_MASK)) begin
        mask <= pwdata[eip_pkg::NUM_SRC-1:0];
      end
      irq <= |(status & mask);
    end
  end

  // Read view of each control register with flag and live pin
  always_comb begin
    for (int i = 0; i < eip_pkg::NUM_SRC; i++) begin
      ctrlView[i] = {flag[i], 8'h00, pinNow[i], 6'(ctrl[i]) & eip_pkg::SRC_WMASK[i][5:0]};
    end
  end

  // Read decode; reserved slots answer zero without error
  always_comb begin
    rdMux  = '0;
    rdHit  = 1'b0;
    rsvHit = 1'b0;
    for (int i = 0; i < eip_pkg::NUM_SRC; i++) begin
      if (paddr == eip_pkg::SRC_ADDR[i]) begin
        rdMux = {16'h0000, ctrlView[i]};
        rdHit = 1'b1;
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (paddr == eip_pkg::RSV_ADDR[i]) begin
        rsvHit = 1'b1;
      end
    end
    if (paddr == eip_pkg::ADDR_VECTOR) begin
      rdMux = {16'h0000, vector};
      rdHit = 1'b1;
    end
    if (paddr == eip_pkg::ADDR_STATUS) begin
      rdMux = {27'h0000000, status};
      rdHit = 1'b1;
    end
    if (paddr == eip_pkg::ADDR_MASK) begin
      rdMux = {27'h0000000, mask};
      rdHit = 1'b1;
    end
    rdHit = rdHit | rsvHit;
  end

  // APB answer: no wait states, data and error registered in setup
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setupPh;
      pslverr <= setupPh & ~rdHit;
      if (setupPh) begin
        prdata <= pwrite ? 32'h00000000 : rdMux;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstSync);

  sequence s_setup_at(logic [eip_pkg::ADDR_W-1:0] a, logic wr);
    psel && !penable && (pwrite == wr) && (paddr == a);
  endsequence

  sequence s_access_done;
    psel && penable && pready;
  endsequence

  property p_one_addr;
    s_access_done and (pwrite && paddr == eip_pkg::ADDR_IRQ_ONE)
      |=> ctrl[eip_pkg::SRC_ONE].en == $past(pwdata[0]);
  endproperty
  a_one_addr: assert property (p_one_addr) else $error("first source enable not written");

  property p_gpio_no_flag;
    ctrl[eip_pkg::SRC_ONE].gpio && !flag[eip_pkg::SRC_ONE] && !wrSel[eip_pkg::SRC_ONE]
      |=> !flag[eip_pkg::SRC_ONE];
  endproperty
  a_gpio_no_flag: assert property (p_gpio_no_flag) else $error("input-only pin raised flag");

  property p_nmi_fwd;
    flag[eip_pkg::SRC_NMI] && ctrl[eip_pkg::SRC_NMI].en |=> coreReq.nmi;
  endproperty
  a_nmi_fwd: assert property (p_nmi_fwd) else $error("nonmaskable request missing");

  property p_two_oe;
    ctrl[eip_pkg::SRC_TWO].gpio && ctrl[eip_pkg::SRC_TWO].dir |=> extIrqTwoOe;
  endproperty
  a_two_oe: assert property (p_two_oe) else $error("second pin not driven");

  property p_three_out;
    ##0 1'b1 |=> extIrqThreeOut == $past(ctrl[eip_pkg::SRC_THREE].dout)
      && extIrqThreeOe == $past(ctrl[eip_pkg::SRC_THREE].gpio && ctrl[eip_pkg::SRC_THREE].dir);
  endproperty
  a_three_out: assert property (p_three_out) else $error("third pin drive wrong");

  property p_protect_hiz;
    srcEvt[eip_pkg::SRC_PROT] && ctrl[eip_pkg::SRC_PROT].en && !wrSel[eip_pkg::SRC_PROT]
      |=> ##1 timerPwmHiZ && coreReq.lineTwo;
  endproperty
  a_protect_hiz: assert property (p_protect_hiz) else $error("protect did not float outputs");

  property p_masked_quiet;
    !ctrl[eip_pkg::SRC_NMI].en |=> !coreReq.nmi;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("disabled source forwarded");

  property p_low_vec;
    ackLineSix && !ackLineOne && lowPend == 3'b010 |=> vector == eip_pkg::VEC_TWO;
  endproperty
  a_low_vec: assert property (p_low_vec) else $error("low line vector wrong");

  property p_high_rank;
    ackLineOne && highPend[0] |=> vector == eip_pkg::VEC_ONE;
  endproperty
  a_high_rank: assert property (p_high_rank) else $error("high line ranking wrong");

  property p_phantom;
    (ackLineOne && highPend == 3'b000) || (!ackLineOne && ackLineSix && lowPend == 3'b000)
      |=> vector == eip_pkg::VEC_PHANTOM;
  endproperty
  a_phantom: assert property (p_phantom) else $error("phantom vector missing");

  property p_rsv_zero;
    s_setup_at(eip_pkg::RSV_ADDR[0], 1'b0) |=> pready && prdata == 32'h00000000 && !pslverr;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved slot not zero");

  property p_three_distinct;
    s_access_done and (pwrite && paddr == eip_pkg::ADDR_IRQ_THREE)
      |=> $stable(ctrl[eip_pkg::SRC_TWO]) && $stable(ctrl[eip_pkg::SRC_ONE]);
  endproperty
  a_three_distinct: assert property (p_three_distinct) else $error("third write leaked");

  property p_irq_level;
    |(status & mask) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt output missing");

endmodule

// [src/eip_pkg.sv]
package eip_pkg;
  // Register indices; the bus byte address is four times the index
  localparam logic [15:0] IDX_IRQ_ONE   = 16'h7070;
  localparam logic [15:0] IDX_NMI       = 16'h7072;
  localparam logic [15:0] IDX_RSV_B0    = 16'h7074;
  localparam logic [15:0] IDX_RSV_B1    = 16'h7076;
  localparam logic [15:0] IDX_IRQ_TWO   = 16'h7078;
  localparam logic [15:0] IDX_IRQ_THREE = 16'h707A;
  localparam logic [15:0] IDX_RSV_PM0   = 16'h707C;
  localparam logic [15:0] IDX_RSV_PM1   = 16'h707E;
  localparam logic [15:0] IDX_PROTECT   = 16'h742C;
  localparam logic [15:0] IDX_VECTOR    = 16'h701E;
  localparam logic [15:0] IDX_STATUS    = 16'h7080;
  localparam logic [15:0] IDX_MASK      = 16'h7082;

  localparam int ADDR_W = 18;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ONE   = {IDX_IRQ_ONE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_NMI       = {IDX_NMI, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_TWO   = {IDX_IRQ_TWO, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_THREE = {IDX_IRQ_THREE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PROTECT   = {IDX_PROTECT, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_VECTOR    = {IDX_VECTOR, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = {IDX_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_MASK      = {IDX_MASK, 2'b00};

  // Source slots, also the bit positions in status and mask
  localparam int SRC_ONE   = 0;
  localparam int SRC_NMI   = 1;
  localparam int SRC_TWO   = 2;
  localparam int SRC_THREE = 3;
  localparam int SRC_PROT  = 4;
  localparam int NUM_SRC   = 5;

  localparam logic [ADDR_W-1:0] SRC_ADDR [NUM_SRC] =
    '{ADDR_IRQ_ONE, ADDR_NMI, ADDR_IRQ_TWO, ADDR_IRQ_THREE, ADDR_PROTECT};
  localparam logic [ADDR_W-1:0] RSV_ADDR [4] =
    '{{IDX_RSV_B0, 2'b00}, {IDX_RSV_B1, 2'b00}, {IDX_RSV_PM0, 2'b00}, {IDX_RSV_PM1, 2'b00}};

  // Writable control bits per source: type A, NMI, type C, protect
  localparam logic [15:0] WMASK_A    = 16'h000F;
  localparam logic [15:0] WMASK_NMI  = 16'h000B;
  localparam logic [15:0] WMASK_C    = 16'h003F;
  localparam logic [15:0] WMASK_PROT = 16'h0001;
  localparam logic [15:0] SRC_WMASK [NUM_SRC] =
    '{WMASK_A, WMASK_NMI, WMASK_C, WMASK_C, WMASK_PROT};

  localparam logic [15:0] CTRL_RESET  = 16'h0000;
  localparam logic [15:0] VEC_PHANTOM = 16'h0000;
  localparam logic [15:0] VEC_ONE     = 16'h0001;
  localparam logic [15:0] VEC_TWO     = 16'h0011;
  localparam logic [15:0] VEC_THREE   = 16'h001F;

  // Control register layout
  typedef struct packed {
    logic       flag;
    logic [7:0] rsvd;
    logic       pin;
    logic       dout;
    logic       dir;
    logic       gpio;
    logic       prio;
    logic       pol;
    logic       en;
  } eip_ctrl_t;

  // Requests toward the core arbitration
  typedef struct packed {
    logic lineOne;
    logic lineTwo;
    logic lineSix;
    logic nmi;
  } eip_core_req_t;
endpackage

// [dv/eip_core_model.sv]
// Core side: acknowledges each new request after a chosen nonzero delay
module eip_core_model (
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  input  wire eip_pkg::eip_core_req_t coreReq,
  input  wire logic [3:0]             ackDelay,
  input  wire logic                   kickOne,
  input  wire logic                   kickSix,
  output logic                        ackLineOne,
  output logic                        ackLineSix
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       prevOne;
  logic       prevSix;
  logic [3:0] cntOne;
  logic [3:0] cntSix;

  // Kicks ack with no request, to reach the phantom path
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prevOne    <= 1'b0;
      prevSix    <= 1'b0;
      cntOne     <= 4'h0;
      cntSix     <= 4'h0;
      ackLineOne <= 1'b0;
      ackLineSix <= 1'b0;
    end else begin
      prevOne    <= coreReq.lineOne;
      prevSix    <= coreReq.lineSix;
      cntOne     <= (coreReq.lineOne && !prevOne) ? ackDelay : (cntOne != 4'h0 ? cntOne - 4'h1 : 4'h0);
      cntSix     <= (coreReq.lineSix && !prevSix) ? ackDelay : (cntSix != 4'h0 ? cntSix - 4'h1 : 4'h0);
      ackLineOne <= kickOne || (cntOne == 4'h1);
      ackLineSix <= kickSix || (cntSix == 4'h1);
    end
  end
endmodule

// [dv/eip_external_irq_tb.sv]
module eip_external_irq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                        sys_clk = 1'b0;
  logic                        rstn = 1'b0;
  logic                        psel = 1'b0;
  logic                        penable = 1'b0;
  logic                        pwrite = 1'b0;
  logic [eip_pkg::ADDR_W-1:0]  paddr = '0;
  logic [31:0]                 pwdata = '0;
  logic [31:0]                 prdata;
  logic                        pready;
  logic                        pslverr;
  logic                        pinOne = 1'b0;
  logic                        nmiPin = 1'b0;
  logic                        pinTwo = 1'b0;
  logic                        pinThree = 1'b0;
  logic                        twoOut;
  logic                        twoOe;
  logic                        threeOut;
  logic                        threeOe;
  logic                        driveFaultN = 1'b1;
  logic                        timerPwmHiZ;
  logic                        ackLineOne;
  logic                        ackLineSix;
  logic [3:0]                  ackDelay = 4'h1;
  logic                        kickOne = 1'b0;
  logic                        kickSix = 1'b0;
  eip_pkg::eip_core_req_t      coreReq;
  logic                        irq;
  int                          miscompares = 0;
  int                          nCompared = 0;
  localparam logic [15:0] VEC [3] = '{eip_pkg::VEC_ONE, eip_pkg::VEC_TWO, eip_pkg::VEC_THREE};
  localparam int          SRC [3] = '{eip_pkg::SRC_ONE, eip_pkg::SRC_TWO, eip_pkg::SRC_THREE};

  always #5 sys_clk = ~sys_clk;

  eip_external_irq i_eip_external_irq (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .extIrqOnePin(pinOne), .nmiPin(nmiPin),
    .extIrqTwoIn(pinTwo), .extIrqTwoOut(twoOut), .extIrqTwoOe(twoOe),
    .extIrqThreeIn(pinThree), .extIrqThreeOut(threeOut), .extIrqThreeOe(threeOe),
    .driveFaultN(driveFaultN), .timerPwmHiZ(timerPwmHiZ), .ackLineOne(ackLineOne),
    .ackLineSix(ackLineSix), .coreReq(coreReq), .irq(irq));

  eip_core_model i_eip_core_model (.sys_clk(sys_clk), .rstn(rstn), .coreReq(coreReq),
    .ackDelay(ackDelay), .kickOne(kickOne), .kickSix(kickSix), .ackLineOne(ackLineOne),
    .ackLineSix(ackLineSix));

  task automatic complete_run();
    if (miscompares == 0 && nCompared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // No cycle count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [17:0] a, input logic [15:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, {16'h0000, d}, rd, err);
  endtask

  // Read, keep the bits in m, compare; also expects no error
  task automatic rdm(input string what, input logic [17:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    check(what, rd & m, exp);
    check({what, " err"}, {31'h0, err}, 32'h0);
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return coreReq.lineOne;
      1: return coreReq.lineTwo;
      2: return coreReq.lineSix;
      3: return coreReq.nmi;
      4: return irq;
      default: return timerPwmHiZ;
    endcase
  endfunction

  // Bounded wait for an output level, then compare
  task automatic waitSig(input string what, input int s, input logic v);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (pick(s) !== v && n < 20);
    check(what, {31'h0, pick(s)}, {31'h0, v});
  endtask

  task automatic setPin(input int k, input logic v);
    @(posedge sys_clk);
    case (k)
      0: pinOne <= v;
      1: pinTwo <= v;
      default: pinThree <= v;
    endcase
  endtask

  task automatic kick(input logic six);
    @(posedge sys_clk);
    if (six) kickSix <= 1'b1;
    else kickOne <= 1'b1;
    @(posedge sys_clk);
    kickOne <= 1'b0;
    kickSix <= 1'b0;
  endtask

  // Hang guard, far beyond the length of the sequence below
  initial begin
    #300us;
    miscompares++;
    complete_run();
  end

  initial begin
    logic [31:0] rd;
    logic        err;
    logic [17:0] a;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    // Reset values; pin level bit left out
    for (int i = 0; i < eip_pkg::NUM_SRC; i++)
      rdm("ctrl reset", eip_pkg::SRC_ADDR[i], 32'hFFBF, 32'h0);
    rdm("vector reset", eip_pkg::ADDR_VECTOR, 32'hFFFF_FFFF, 32'h0);
    rdm("status reset", eip_pkg::ADDR_STATUS, 32'hFFFF_FFFF, 32'h0);
    // Writable bits per register, each read back right after its own all-ones write
    for (int i = 0; i < eip_pkg::NUM_SRC; i++) begin
      wr(eip_pkg::SRC_ADDR[i], 16'hFFFF);
      rdm("ctrl bits", eip_pkg::SRC_ADDR[i], 32'h3F, {16'h0, eip_pkg::SRC_WMASK[i]});
    end
    check("pin two drive", {30'h0, twoOe, twoOut}, 32'h3);
    check("pin three drive", {30'h0, threeOe, threeOut}, 32'h3);
    for (int i = 0; i < eip_pkg::NUM_SRC; i++)
      wr(eip_pkg::SRC_ADDR[i], 16'h0000);
    for (int j = 0; j < 4; j++) begin
      wr(eip_pkg::RSV_ADDR[j], 16'hFFFF);
      rdm("reserved", eip_pkg::RSV_ADDR[j], 32'hFFFF_FFFF, 32'h0);
    end
    apb(1'b0, 18'h00100, 32'h0, rd, err);
    check("unmapped err", {31'h0, err}, 32'h1);
    wr(eip_pkg::ADDR_MASK, 16'h001F);
    // Each user source at low and at high priority, prompt and slow acks
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 3; k++) begin
        a = eip_pkg::SRC_ADDR[SRC[k]];
        ackDelay <= 4'(k * 4 + 1);
        wr(a, p == 0 ? 16'h0007 : 16'h0003);
        setPin(k, 1'b1);
        waitSig("line req", p == 0 ? 2 : 0, 1'b1);
        waitSig("irq out", 4, 1'b1);
        repeat (14) @(posedge sys_clk);
        rdm("vector", eip_pkg::ADDR_VECTOR, 32'hFFFF_FFFF, {16'h0, VEC[k]});
        rdm("status", eip_pkg::ADDR_STATUS, 32'h1F, 32'(1) << SRC[k]);
        wr(a, p == 0 ? 16'h8007 : 16'h8003);
        waitSig("line drop", p == 0 ? 2 : 0, 1'b0);
        setPin(k, 1'b0);
        wr(a, 16'h0000);
      end
    end
    // All three at once: ranking, then next in line after clearing the first
    for (int k = 0; k < 3; k++) begin
      wr(eip_pkg::SRC_ADDR[SRC[k]], 16'h0003);
      setPin(k, 1'b1);
    end
    waitSig("line one all", 0, 1'b1);
    repeat (20) @(posedge sys_clk);
    rdm("rank first", eip_pkg::ADDR_VECTOR, 32'hFFFF, {16'h0, eip_pkg::VEC_ONE});
    wr(eip_pkg::ADDR_IRQ_ONE, 16'h8003);
    kick(1'b0);
    repeat (2) @(posedge sys_clk);
    rdm("rank second", eip_pkg::ADDR_VECTOR, 32'hFFFF, {16'h0, eip_pkg::VEC_TWO});
    for (int k = 0; k < 3; k++) begin
      wr(eip_pkg::SRC_ADDR[SRC[k]], 16'h8000);
      setPin(k, 1'b0);
    end
    kick(1'b1);
    repeat (2) @(posedge sys_clk);
    rdm("phantom", eip_pkg::ADDR_VECTOR, 32'hFFFF, {16'h0, eip_pkg::VEC_PHANTOM});
    // Flag without enable stays local; mask holds irq down
    wr(eip_pkg::ADDR_MASK, 16'h0000);
    rdm("status drain", eip_pkg::ADDR_STATUS, 32'h1F, 32'hD);
    wr(eip_pkg::ADDR_IRQ_TWO, 16'h0002);
    setPin(1, 1'b1);
    repeat (8) @(posedge sys_clk);
    check("no enable", {31'h0, coreReq.lineOne}, 32'h0);
    check("masked irq", {31'h0, irq}, 32'h0);
    wr(eip_pkg::ADDR_IRQ_TWO, 16'h0003);
    waitSig("late enable", 0, 1'b1);
    wr(eip_pkg::ADDR_MASK, 16'h001F);
    waitSig("unmasked irq", 4, 1'b1);
    rdm("status two", eip_pkg::ADDR_STATUS, 32'h1F, 32'h4);
    waitSig("irq cleared", 4, 1'b0);
    wr(eip_pkg::ADDR_IRQ_TWO, 16'h8000);
    setPin(1, 1'b0);
    // Drive protect: enabled floats outputs on line two; disabled leaves outputs driven
    wr(eip_pkg::ADDR_PROTECT, 16'h0001);
    @(posedge sys_clk);
    driveFaultN <= 1'b0;
    waitSig("hi z", 5, 1'b1);
    waitSig("line two", 1, 1'b1);
    wr(eip_pkg::ADDR_PROTECT, 16'h8000);
    waitSig("line two off", 1, 1'b0);
    @(posedge sys_clk);
    driveFaultN <= 1'b1;
    repeat (3) @(posedge sys_clk);
    driveFaultN <= 1'b0;
    repeat (8) @(posedge sys_clk);
    check("hi z masked", {31'h0, timerPwmHiZ}, 32'h0);
    driveFaultN <= 1'b1;
    // Nonmaskable request, then the same pin as plain input
    wr(eip_pkg::ADDR_NMI, 16'h0003);
    @(posedge sys_clk);
    nmiPin <= 1'b1;
    waitSig("nmi req", 3, 1'b1);
    wr(eip_pkg::ADDR_NMI, 16'h800B);
    @(posedge sys_clk);
    nmiPin <= 1'b0;
    waitSig("nmi off", 3, 1'b0);
    @(posedge sys_clk);
    nmiPin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check("nmi gpio", {31'h0, coreReq.nmi}, 32'h0);
    rdm("nmi pin level", eip_pkg::ADDR_NMI, 32'h40, 32'h40);
    complete_run();
  end
endmodule
